// >>> idle_mode_clock_gating_tb_top.sv
// Self-checking bench of the idle clock gating block.
`default_nettype none
`include "imc_idle_defines.vh"
module idle_mode_clock_gating_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [1:0] IDL = `IMC_MODE_IDLE, ACT = `IMC_MODE_ACTIVE, PDN = `IMC_MODE_PDOWN;
  logic clk_i = 0, rst_n_i = 0, wr = 0, irq = 0, ovf = 0, slow = 0;
  logic val = 1, pdr = 0, pdw = 0;
  logic [3:0] per = '0;
  logic [7:0] drv = '0, p;
  logic [8:0] e, q[$];
  logic [31:0] s = 32'h98684D30;
  wire wk, wd, cke, osc, sbit, slw;
  wire [1:0] md;
  wire [3:0] pen;
  wire [7:0] pin;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  imc_idle_ctrl i_dut (.clk_i, .rst_n_i, .sleep_req_wr_i(wr), .sleep_req_val_i(val),
    .slowdown_bit_i(slow), .pdown_req_i(pdr), .irq_pending_i(irq),
    .watchdog_counter_ovf_i(ovf), .pdown_wake_i(pdw), .periph_clk_on_i(per),
    .port_drive_i(drv), .core_clk_en_o(cke), .osc_run_o(osc), .slow_clk_sel_o(slw),
    .periph_clk_en_o(pen), .port_pin_o(pin), .mode_o(md), .core_sleep_request_bit_o(sbit),
    .irq_wake_o(wk), .watchdog_rst_o(wd));
  initial forever #2 clk_i = ~clk_i;
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input logic [8:0] x);
    cmp_count++;
    if ({wd, wk, md, cke, sbit, pin} !== {x[8], ~x[8], ACT, 2'h2, x[7:0]}) begin
      error_cnt++;
      $display("wrong value at %0t: wake %h", $time, {wd, wk, md, cke, sbit, pin});
    end
  endtask
  task automatic cmp_st(input logic [1:0] m, input logic c, o, b, sl, input logic [3:0] pe,
    input logic [7:0] pv);
    cmp_count++;
    if ({md, cke, osc, sbit, slw, pen, pin} !== {m, c, o, b, sl, pe, pv}) begin
      error_cnt++;
      $display("wrong value at %0t: state %h", $time, {md, cke, osc, sbit, slw, pen, pin});
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // An empty queue gives an unknown note, so a stray wake always mismatches.
  always @(negedge clk_i) if (wk === 1'h1 || wd === 1'h1) begin
    e = q.size() ? q.pop_front() : 'x;
    cmp(e);
  end
  always @(posedge clk_i) if (++cyc > 3000) begin
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_n_i = 1;
    for (int i = 0; i < 40; i++) begin
      s = nx(s);
      p = s[7:0];
      @(posedge clk_i) #1 {irq, ovf, slow, per} = s[15:9];
      @(posedge clk_i) #1 {irq, ovf, wr, drv} = {3'h1, p};
      @(posedge clk_i) #1 {wr, drv} = {1'h0, ~p};
      @(negedge clk_i) cmp_st(IDL, 1'h0, 1'h1, 1'h1, slow, per, p);
      repeat (s[25:24]) @(posedge clk_i);
      @(posedge clk_i) #1 {irq, ovf} = {1'h1, s[26]};
      q.push_back({s[26], p});
      @(posedge clk_i) #1 {irq, ovf} = 2'h0;
      $display("test %0d done", i);
    end
    @(posedge clk_i) #1 pdr = 1;
    @(posedge clk_i) #1 pdr = 0;
    @(negedge clk_i) cmp_st(PDN, 1'h0, 1'h0, 1'h0, slow, 4'h0, drv);
    @(posedge clk_i) #1 pdw = 1;
    @(posedge clk_i) #1 {pdw, wr} = 2'h1;
    @(negedge clk_i) cmp_st(ACT, 1'h1, 1'h1, 1'h0, slow, per, drv);
    $display("test power-down done");
    @(posedge clk_i) #1 val = 0;
    @(posedge clk_i) #1 val = 1;
    @(negedge clk_i) cmp_st(IDL, 1'h0, 1'h1, 1'h0, slow, per, drv);
    @(posedge clk_i) #1 {wr, rst_n_i} = 2'h0;
    @(negedge clk_i) cmp_st(IDL, 1'h0, 1'h1, 1'h1, slow, per, drv);
    @(posedge clk_i);
    @(negedge clk_i) cmp_st(ACT, 1'h1, 1'h1, 1'h0, 1'h0, `IMC_PERIPH_RST, `IMC_PORT_RST);
    @(posedge clk_i) #1 rst_n_i = 1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) cmp_st(ACT, 1'h1, 1'h1, 1'h0, slow, per, drv);
    $display("test reset done");
    complete_run();
  end
endmodule // idle_mode_clock_gating_tb_top
`default_nettype wire

// >>> imc_idle_checker.sv
// Checker of the idle clock gating block.
`default_nettype none
`include "imc_idle_defines.vh"
module imc_idle_checker (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Inputs of the block.
  input wire logic sleep_req_wr_i,
  input wire logic sleep_req_val_i,
  input wire logic irq_pending_i,
  input wire logic watchdog_counter_ovf_i,
  input wire logic [3:0] periph_clk_on_i,
  // Outputs of the block.
  input wire logic core_clk_en_o,
  input wire logic osc_run_o,
  input wire logic [3:0] periph_clk_en_o,
  input wire logic [7:0] port_pin_o,
  input wire logic [1:0] mode_o,
  input wire logic core_sleep_request_bit_o,
  input wire logic irq_wake_o,
  input wire logic watchdog_rst_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire idl = mode_o == `IMC_MODE_IDLE;
  wire act = mode_o == `IMC_MODE_ACTIVE;
  wire req = sleep_req_wr_i && sleep_req_val_i;
  wire irq = irq_pending_i;
  wire ovf = watchdog_counter_ovf_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RST: assert property ($rose(rst_n_i) |-> act && core_clk_en_o)
    else $error("not active");
  AST_GO: assert property (act && req |=> idl && !core_clk_en_o)
    else $error("no idle");
  AST_OSC: assert property (idl |-> osc_run_o)
    else $error("osc off");
  AST_PER: assert property (idl |=> periph_clk_en_o == $past(periph_clk_on_i))
    else $error("periph clock");
  AST_PIN: assert property (idl && $past(idl) |-> $stable(port_pin_o))
    else $error("pins moved");
  AST_STAY: assert property (idl && !irq && !ovf |=> idl && !core_clk_en_o)
    else $error("left idle");
  AST_IRQ: assert property (idl && irq && !ovf |=> act && irq_wake_o)
    else $error("no wake");
  AST_CLR: assert property (idl && (irq || ovf) && !req |=> !core_sleep_request_bit_o)
    else $error("bit kept");
  AST_WDT: assert property (idl && ovf |=> act && watchdog_rst_o && !irq_wake_o)
    else $error("no watchdog exit");
  AST_CAUSE: assert property (irq_wake_o |-> $past(idl) && $past(irq))
    else $error("stray wake");
  cover property (act && req);
  cover property (idl && irq);
  cover property (idl && ovf);
endmodule // imc_idle_checker
bind imc_idle_ctrl imc_idle_checker i_chk (.*);
`default_nettype wire

// >>> imc_idle_ctrl.v
// Power-mode controller: active, idle, slow-down select and power-down.
`default_nettype none
`include "imc_idle_defines.vh"

module imc_idle_ctrl (
  // Clock and synchronous reset.
  input wire clk_i,
  input wire rst_n_i,
  // Software requests from the core.
  input wire sleep_req_wr_i,
  input wire sleep_req_val_i,
  input wire slowdown_bit_i,
  input wire pdown_req_i,
  // Wake and abort events.
  input wire irq_pending_i,
  input wire watchdog_counter_ovf_i,
  input wire pdown_wake_i,
  // Peripheral clock enables chosen by software.
  input wire [`IMC_PERIPH_W-1:0] periph_clk_on_i,
  // Port levels the core wants to drive.
  input wire [`IMC_PORT_W-1:0] port_drive_i,
  // Clock gate controls.
  output wire core_clk_en_o,
  output wire osc_run_o,
  output wire slow_clk_sel_o,
  output wire [`IMC_PERIPH_W-1:0] periph_clk_en_o,
  // Port pins.
  output wire [`IMC_PORT_W-1:0] port_pin_o,
  // Status and events.
  output wire [`IMC_MODE_W-1:0] mode_o,
  output wire core_sleep_request_bit_o,
  output wire irq_wake_o,
  output wire watchdog_rst_o
);

  localparam [1:0] ST_ACTIVE = `IMC_MODE_ACTIVE;
  localparam [1:0] ST_IDLE = `IMC_MODE_IDLE;
  localparam [1:0] ST_PDOWN = `IMC_MODE_PDOWN;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg sleep_bit_q;
  reg sleep_bit_d;
  reg core_en_q;
  reg core_en_d;
  reg osc_q;
  reg osc_d;
  reg slow_q;
  reg [`IMC_PERIPH_W-1:0] periph_q;
  reg [`IMC_PERIPH_W-1:0] periph_d;
  reg [`IMC_PORT_W-1:0] port_q;
  reg [`IMC_PORT_W-1:0] port_d;
  reg wake_q;
  reg wake_d;
  reg wdrst_q;
  reg wdrst_d;

  wire sleep_set;
  wire exit_irq;
  wire exit_wdt;

  // A write of one is the only way into idle.
  assign sleep_set = sleep_req_wr_i & sleep_req_val_i; // [R09]
  assign exit_irq = (state_q == ST_IDLE) & irq_pending_i; // [R10]
  assign exit_wdt = (state_q == ST_IDLE) & watchdog_counter_ovf_i; // [R06]

  // Next mode.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: begin
        // Idle is taken before power-down when both ask in one cycle.
        if (sleep_set) begin
          state_d = ST_IDLE; // [R02] [R09]
        end else if (pdown_req_i) begin
          state_d = ST_PDOWN; // [R02]
        end
      end
      ST_IDLE: begin
        if (exit_wdt | exit_irq) begin
          state_d = ST_ACTIVE; // [R06] [R10]
        end
      end
      ST_PDOWN: begin
        if (pdown_wake_i) begin
          state_d = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
  end

  // Request bit: a fresh write wins over the self-clear on exit.
  always @* begin
    sleep_bit_d = sleep_bit_q;
    if (sleep_req_wr_i & ~sleep_req_val_i) begin
      sleep_bit_d = 1'h0;
    end
    if ((state_q == ST_IDLE) && (state_d != ST_IDLE)) begin
      sleep_bit_d = 1'h0; // [R13]
    end
    if (sleep_set) begin
      sleep_bit_d = 1'h1; // [R09]
    end
  end

  // Clock gates follow the next mode so the core stops on the cycle after the write.
  always @* begin
    core_en_d = 1'h1;
    osc_d = 1'h1;
    periph_d = periph_clk_on_i;
    case (state_d)
      ST_ACTIVE: begin
        core_en_d = 1'h1; // [R01] [R10]
      end
      ST_IDLE: begin
        // Gating the core clock freezes every core register in place.
        core_en_d = 1'h0; // [R03] [R07]
        osc_d = 1'h1; // [R04]
        periph_d = periph_clk_on_i; // [R05]
      end
      ST_PDOWN: begin
        // Peripherals lose their clocks here whatever software enabled.
        core_en_d = 1'h0;
        osc_d = 1'h0;
        periph_d = {`IMC_PERIPH_W{1'h0}};
      end
      default: begin
        core_en_d = 1'h1;
      end
    endcase
  end

  // Pins follow the core while active, so the entry edge captures the last
  // levels, and hold them in every other mode.
  always @* begin
    port_d = port_q;
    case (state_q)
      ST_ACTIVE: begin
        port_d = port_drive_i; // [R08]
      end
      ST_IDLE: begin
        port_d = port_q; // [R08]
      end
      ST_PDOWN: begin
        port_d = port_q;
      end
      default: begin
        port_d = port_drive_i;
      end
    endcase
  end

  // One-cycle event pulses.
  always @* begin
    wake_d = exit_irq & ~exit_wdt; // [R10]
    wdrst_d = exit_wdt; // [R06]
  end

  // The resume address needs no storage: the core halted with its
  // program counter already past the write, so the interrupt return
  // lands on the following instruction.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_ACTIVE; // [R01] [R12]
      sleep_bit_q <= `IMC_SLEEP_BIT_RST; // [R12]
    end else begin
      state_q <= state_d;
      sleep_bit_q <= sleep_bit_d;
    end
  end

  // Clock gate controls. Slow-down is kept apart from the mode, so it
  // persists through idle and only software or a reset can end it.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      core_en_q <= `IMC_CORE_EN_RST; // [R01]
      osc_q <= `IMC_OSC_RST;
      slow_q <= `IMC_SLOW_RST;
      periph_q <= `IMC_PERIPH_RST;
    end else begin
      core_en_q <= core_en_d; // [R11]
      osc_q <= osc_d;
      slow_q <= slowdown_bit_i; // [R02]
      periph_q <= periph_d;
    end
  end

  // Port pins.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_q <= `IMC_PORT_RST; // [R12]
    end else begin
      port_q <= port_d;
    end
  end

  // Event pulses; the watchdog pulse is meant to drive the internal reset.
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wake_q <= `IMC_PULSE_RST;
      wdrst_q <= `IMC_PULSE_RST;
    end else begin
      wake_q <= wake_d;
      wdrst_q <= wdrst_d;
    end
  end

  assign core_clk_en_o = core_en_q;
  assign osc_run_o = osc_q;
  assign slow_clk_sel_o = slow_q;
  assign periph_clk_en_o = periph_q;
  assign port_pin_o = port_q;
  assign mode_o = state_q;
  assign core_sleep_request_bit_o = sleep_bit_q;
  assign irq_wake_o = wake_q;
  assign watchdog_rst_o = wdrst_q;

endmodule // imc_idle_ctrl

`default_nettype wire

// >>> imc_idle_defines.vh
// Constants for the idle-mode clock gating block.
// Operation
// R01: After any reset the block starts in active mode with core and peripherals on the system clock.
// R02: From active mode software may choose idle, slow-down or power-down.
// R03: In idle mode the core clock is gated off so that execution halts.
// R04: Entering idle leaves the oscillator running and withholds only the core clock.
// R05: In idle every peripheral whose own clock is enabled keeps its clock.
// R06: A watchdog overflow during idle raises an internal reset that ends idle.
// R07: All processor state is kept unchanged throughout idle.
// R08: Port pins keep the levels they had when idle was entered.
// R09: Writing a one to the core sleep request bit places the device in idle.
// R10: Any enabled interrupt ends idle, restores the core clock and lets it be serviced.
// R11: After the interrupt return, execution continues after the instruction that set the bit.
// R12: The external hard reset ends idle and the normal reset behaviour follows.
// R13: The core sleep request bit clears itself when idle is left.
`ifndef IMC_IDLE_DEFINES_VH
`define IMC_IDLE_DEFINES_VH

`define IMC_MODE_W 2
`define IMC_MODE_ACTIVE 2'h0
`define IMC_MODE_IDLE 2'h1
`define IMC_MODE_PDOWN 2'h2

`define IMC_PORT_W 8
`define IMC_PERIPH_W 4
`define IMC_PORT_RST 8'hFF
`define IMC_PERIPH_RST 4'hF
`define IMC_CORE_EN_RST 1'h1
`define IMC_OSC_RST 1'h1
`define IMC_SLOW_RST 1'h0
`define IMC_SLEEP_BIT_RST 1'h0
`define IMC_PULSE_RST 1'h0

`endif
